// ===== ltfc_pkg.sv
// shared constants for the line transmit framer control block
package ltfc_pkg;

    // ------------------------------------------------------------
    // register offsets on the processor port
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_FRAME_CTRL = 8'ha3;
    localparam logic [7:0] OFS_TEST_CTRL  = 8'ha4;
    localparam logic [7:0] OFS_SLOT_SEL   = 8'ha5;
    localparam logic [7:0] OFS_SAMPLE_HI  = 8'ha6;
    localparam logic [7:0] OFS_SAMPLE_LO  = 8'ha7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] FRAME_CTRL_RST = 8'h08;
    localparam logic [7:0] TEST_CTRL_RST  = 8'h00;
    localparam logic [7:0] SLOT_SEL_RST   = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int FC_LEVEL_FINE  = 6;
    localparam int FC_FIFO_RST    = 5;
    localparam int FC_FRM_RST     = 4;
    localparam int FC_ALIGN_DIS   = 3;
    localparam int FC_SLIP_DIS    = 2;
    localparam int FC_EMPTY_DIS   = 1;
    localparam int FC_FORCE_STUFF = 0;
    localparam logic [7:0] FC_WMASK = 8'h7f;
    localparam int TC_FREEZE      = 2;
    localparam int TC_CRC_INJ     = 1;
    localparam int TC_FSW_INJ     = 0;
    localparam int SEL_W          = 6;

    // ------------------------------------------------------------
    // buffer and frame geometry
    // ------------------------------------------------------------
    localparam int FIFO_BITS      = 80;
    localparam int FIFO_LEAD      = 40;
    localparam int T1_FRAME_BITS  = 193;
    localparam int T1_SLOTS       = 24;
    localparam int LINE_FRAME_BITS = 4096;

endpackage : ltfc_pkg

// ===== ltfc_slot_sampler.sv
// captures one outgoing T1 payload timeslot byte, msb first
`timescale 1ns/100ps
module ltfc_slot_sampler #(
    parameter int SLOT_OFS = 0
) (
    input  wire logic                       ref_clk,   // block clock
    input  wire logic                       rst_n,     // sync reset, active low
    input  wire logic                       clk_en,    // freezes state when low
    input  wire logic                       bit_valid, // t1 bit strobe
    input  wire logic                       bit_in,    // t1 data bit
    input  wire logic [7:0]                 bit_pos,   // position in t1 frame
    input  wire logic [ltfc_pkg::SEL_W-1:0] slot_sel,  // selected timeslot
    output logic      [7:0]                 sample     // last captured byte
);
    logic [7:0] shift_r, shift_nxt;
    logic [7:0] sample_r, sample_nxt;
    logic [7:0] tgt;
    logic [7:0] last_pos;

    // ------------------------------------------------------------
    // capture
    // ------------------------------------------------------------
    always_comb begin
        tgt = {2'b00, slot_sel} + 8'(SLOT_OFS);
        if (tgt >= 8'(ltfc_pkg::T1_SLOTS)) begin
            tgt = tgt - 8'(ltfc_pkg::T1_SLOTS);
        end
        last_pos   = {tgt[4:0], 3'b000} + 8'h08;
        shift_nxt  = shift_r;
        sample_nxt = sample_r;
        if (bit_valid) begin
            shift_nxt = {shift_r[6:0], bit_in};
            // slot plus offset of 48 or more, still out of range after one wrap, keeps the old byte
            if (tgt < 8'(ltfc_pkg::T1_SLOTS) && bit_pos == last_pos) begin
                sample_nxt = {shift_r[6:0], bit_in}; // [RQ15] [RQ16]
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            shift_r  <= 8'h00;
            sample_r <= 8'h00;
        end else if (clk_en) begin
            shift_r  <= shift_nxt;
            sample_r <= sample_nxt;
        end
    end

    assign sample = sample_r;

endmodule : ltfc_slot_sampler

// ===== ltfc_t1_src.sv
// t1 framer model: marker pulse, then 193 bits with one strobe every two cycles
`timescale 1ns/100ps
module ltfc_t1_src (
    input  wire logic ref_clk,           // block clock
    input  wire logic run,               // send frames while high
    output logic      t1_bit_valid,      // bit strobe
    output logic      t1_bit_in,         // payload bit
    output logic      t1_frame_marker_in // frame marker
);
    int         p;
    logic [7:0] b;
    initial begin
        t1_bit_valid = 0;
        t1_bit_in = 0;
        t1_frame_marker_in = 0;
        forever begin
            @(negedge ref_clk);
            if (run) begin
                t1_frame_marker_in = 1;
                repeat (2) @(negedge ref_clk);
                t1_frame_marker_in = 0;
                // room for the marker synchroniser before the framing bit
                repeat (6) @(negedge ref_clk);
                for (p = 0; p < 193; p++) begin
                    b = 8'h5a ^ 8'((p - 1) / 8); // slot k carries 5a^k
                    t1_bit_valid = 1;
                    t1_bit_in = (p == 0) ? 1'b1 : b[7 - (p - 1) % 8];
                    @(negedge ref_clk);
                    t1_bit_valid = 0;
                    // no stale value between strobes
                    t1_bit_in = ~t1_bit_in;
                    @(negedge ref_clk);
                end
            end
        end
    end
endmodule : ltfc_t1_src

// ===== ltfc_top.sv
// transmit framer control registers, elastic buffer, stuffing and monitors
// Contract
// RQ1: water level reads in 0.25 UI steps when fine bit set, else 0.50 UI
// RQ2: fifo pointer reset bit written high then low resets buffer pointers
// RQ3: frame reset bit written high then low resets the line frame counter
// RQ4: alignment disable set: line frame ignores the t1 frame marker
// RQ5: alignment disable clear: line frame forced onto t1 frame marker
// RQ6: slip disable set clears overflow/underflow flags and blocks them
// RQ7: frame interrupt disable set clears empty flag and blocks frame events
// RQ8: forced stuffing inserts stuff bits every second line frame
// RQ9: automatic stuffing compares water level against reference level
// RQ10: freeze blocks buffer writes; held 80 bits are resent repeatedly
// RQ11: crc inject bit corrupts crc of one frame then self-clears
// RQ12: sync word inject bit corrupts sync word of one frame then self-clears
// RQ13: six-bit selector picks a pair of outgoing t1 timeslots to monitor
// RQ14: host waits one frame after changing selector before reading samples
// RQ15: high sample holds the selected timeslot byte, read only
// RQ16: low sample holds the following timeslot byte, read only
// RQ17: host writes zero to reserved bits of control and selector registers
// RQ18: fill above reference gives no stuff bits, below gives four
// RQ19: buffer holds 80 bits, write pointer leads read pointer by 40
// RQ20: injection bits clear after the corrupted frame; mid-frame writes wait
`timescale 1ns/100ps
module ltfc_top #(
    parameter int FRAME_BITS = ltfc_pkg::LINE_FRAME_BITS
) (
    input  wire logic       ref_clk,            // 20 MHz block clock
    input  wire logic       rst_n,              // sync reset, active low
    input  wire logic       clk_en,             // freezes all state when low
    input  wire logic       reg_cs,             // processor port select
    input  wire logic       reg_wr,             // write strobe
    input  wire logic       reg_rd,             // read strobe
    input  wire logic [7:0] reg_addr,           // register address
    input  wire logic [7:0] reg_wdata,          // write data
    output logic      [7:0] reg_rdata,          // read data, one cycle later
    input  wire logic [7:0] ref_water_level,    // signed reference level
    input  wire logic       t1_bit_valid,       // t1 payload bit strobe
    input  wire logic       t1_bit_in,          // t1 payload bit
    input  wire logic       t1_frame_marker_in, // t1 frame marker pin
    input  wire logic       line_bit_req,       // line side takes one bit
    output logic            line_bit_out,       // bit read from buffer
    output logic [7:0]      actual_water_level, // signed fill level
    output logic            frame_start,        // pulse: new line frame
    output logic            stuff_four,         // four stuff bits this frame
    output logic            crc_corrupt,        // corrupt crc this frame
    output logic            sync_word_corrupt,  // corrupt sync word this frame
    output logic            overflow_flag,      // buffer overflow alarm
    output logic            underflow_flag,     // buffer underflow alarm
    output logic            slip_irq,           // buffer interrupt pending
    output logic            frame_empty_flag,   // frame event flag
    output logic            frame_irq           // frame interrupt pending
);
    localparam logic [6:0]  LAST_PTR   = 7'(ltfc_pkg::FIFO_BITS - 1);
    localparam logic [6:0]  LEAD_PTR   = 7'(ltfc_pkg::FIFO_LEAD);
    localparam logic [15:0] LAST_FRAME = 16'(FRAME_BITS - 1);
    localparam logic [7:0]  LAST_T1    = 8'(ltfc_pkg::T1_FRAME_BITS - 1);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  fc_r, fc_nxt;
    logic        freeze_r, freeze_nxt;
    logic        crc_req_r, crc_req_nxt, crc_act_r, crc_act_nxt;
    logic        fsw_req_r, fsw_req_nxt, fsw_act_r, fsw_act_nxt;
    logic [5:0]  sel_r, sel_nxt;
    logic [79:0] mem_r, mem_nxt;
    logic [6:0]  wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic        line_bit_r, line_bit_nxt;
    logic        ovf_r, ovf_nxt, unf_r, unf_nxt, empty_r, empty_nxt;
    logic [15:0] frame_cnt_r, frame_cnt_nxt;
    logic        stuff_r, stuff_nxt;
    logic [7:0]  t1_pos_r, t1_pos_nxt;
    logic [7:0]  rdata_r, rdata_nxt;
    logic        mk_s1_r, mk_s2_r, mk_s3_r;

    logic        wr_fc, wr_tc, wr_sel, fifo_rst_evt, frm_rst_evt;
    logic        marker_rise, align_evt, frame_wrap, do_write;
    logic [6:0]  fill;
    logic signed [9:0] level_wide;
    logic [7:0]  level_sat;
    logic [7:0]  sample_hi, sample_lo;

    // ------------------------------------------------------------
    // decode and events
    // ------------------------------------------------------------
    always_comb begin
        wr_fc  = reg_cs && reg_wr && reg_addr == ltfc_pkg::OFS_FRAME_CTRL;
        wr_tc  = reg_cs && reg_wr && reg_addr == ltfc_pkg::OFS_TEST_CTRL;
        wr_sel = reg_cs && reg_wr && reg_addr == ltfc_pkg::OFS_SLOT_SEL;
        // reset acts on the falling write, i.e. the high-then-low sequence
        fifo_rst_evt = wr_fc && fc_r[ltfc_pkg::FC_FIFO_RST]
                       && !reg_wdata[ltfc_pkg::FC_FIFO_RST]; // [RQ2]
        frm_rst_evt  = wr_fc && fc_r[ltfc_pkg::FC_FRM_RST]
                       && !reg_wdata[ltfc_pkg::FC_FRM_RST];  // [RQ3]
        marker_rise = mk_s2_r && !mk_s3_r;
        align_evt   = marker_rise && !fc_r[ltfc_pkg::FC_ALIGN_DIS]; // [RQ4] [RQ5]
        frame_wrap  = line_bit_req && frame_cnt_r == LAST_FRAME;
        do_write    = t1_bit_valid && !freeze_r; // [RQ10]
        fill = (wr_ptr_r >= rd_ptr_r) ? wr_ptr_r - rd_ptr_r
                                      : 7'(wr_ptr_r + 7'(ltfc_pkg::FIFO_BITS) - rd_ptr_r);
        // level has direction: zero at the nominal 40-bit lead
        level_wide = 10'(signed'({3'b000, fill})) - 10'(ltfc_pkg::FIFO_LEAD);
        level_wide = fc_r[ltfc_pkg::FC_LEVEL_FINE] ? level_wide <<< 2
                                                   : level_wide <<< 1; // [RQ1]
        if (level_wide > 10'sd127) begin
            level_sat = 8'h7f;
        end else if (level_wide < -10'sd128) begin
            level_sat = 8'h80;
        end else begin
            level_sat = level_wide[7:0];
        end
    end

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        fc_nxt        = fc_r;
        freeze_nxt    = freeze_r;
        crc_req_nxt   = crc_req_r;
        crc_act_nxt   = crc_act_r;
        fsw_req_nxt   = fsw_req_r;
        fsw_act_nxt   = fsw_act_r;
        sel_nxt       = sel_r;
        mem_nxt       = mem_r;
        wr_ptr_nxt    = wr_ptr_r;
        rd_ptr_nxt    = rd_ptr_r;
        line_bit_nxt  = line_bit_r;
        ovf_nxt       = ovf_r;
        unf_nxt       = unf_r;
        empty_nxt     = empty_r;
        frame_cnt_nxt = frame_cnt_r;
        stuff_nxt     = stuff_r;
        t1_pos_nxt    = t1_pos_r;
        rdata_nxt     = rdata_r;

        // buffer write and read; one bit per strobe or request in the 80-bit ring
        if (do_write) begin
            mem_nxt[wr_ptr_r] = t1_bit_in;
            wr_ptr_nxt = (wr_ptr_r == LAST_PTR) ? 7'h00 : wr_ptr_r + 7'h01; // [RQ19]
            if (fill == LAST_PTR && !line_bit_req) begin
                ovf_nxt = 1'b1;
            end
        end
        if (line_bit_req) begin
            line_bit_nxt = mem_r[rd_ptr_r];
            rd_ptr_nxt = (rd_ptr_r == LAST_PTR) ? 7'h00 : rd_ptr_r + 7'h01; // [RQ10]
            if (fill == 7'h00 && !do_write) begin
                unf_nxt = 1'b1;
            end
        end
        if (fifo_rst_evt) begin
            rd_ptr_nxt = 7'h00;
            wr_ptr_nxt = LEAD_PTR; // [RQ2] [RQ19]
        end
        if (fc_r[ltfc_pkg::FC_SLIP_DIS]) begin
            ovf_nxt = 1'b0;
            unf_nxt = 1'b0; // [RQ6]
        end

        // line frame counter
        if (line_bit_req) begin
            frame_cnt_nxt = frame_wrap ? 16'h0000 : frame_cnt_r + 16'h0001;
        end
        if (align_evt || frm_rst_evt) begin
            frame_cnt_nxt = 16'h0000; // [RQ3] [RQ5]
        end

        // per-frame decisions, taken only at a frame boundary
        if (frame_start) begin
            if (fc_r[ltfc_pkg::FC_FORCE_STUFF]) begin
                stuff_nxt = !stuff_r; // [RQ8]
            end else begin
                stuff_nxt = $signed(level_sat) < $signed(ref_water_level); // [RQ9] [RQ18]
            end
            crc_act_nxt = crc_req_r && !crc_act_r;
            fsw_act_nxt = fsw_req_r && !fsw_act_r;
            if (crc_act_r) begin
                crc_req_nxt = 1'b0; // [RQ11] [RQ20]
            end
            if (fsw_act_r) begin
                fsw_req_nxt = 1'b0; // [RQ12] [RQ20]
            end
            empty_nxt = 1'b1;
        end
        if (fc_r[ltfc_pkg::FC_EMPTY_DIS]) begin
            empty_nxt = 1'b0; // [RQ7]
        end

        // t1 bit position; framing bit is position 0
        if (t1_bit_valid) begin
            t1_pos_nxt = (t1_pos_r == LAST_T1) ? 8'h00 : t1_pos_r + 8'h01;
        end
        if (marker_rise) begin
            t1_pos_nxt = 8'h00;
        end

        // register writes; a host set wins over the self-clear
        if (wr_fc) begin
            fc_nxt = reg_wdata & ltfc_pkg::FC_WMASK;
        end
        if (wr_tc) begin
            freeze_nxt = reg_wdata[ltfc_pkg::TC_FREEZE];
            if (reg_wdata[ltfc_pkg::TC_CRC_INJ]) begin
                crc_req_nxt = 1'b1; // [RQ11]
            end
            if (reg_wdata[ltfc_pkg::TC_FSW_INJ]) begin
                fsw_req_nxt = 1'b1; // [RQ12]
            end
        end
        if (wr_sel) begin
            sel_nxt = reg_wdata[ltfc_pkg::SEL_W-1:0]; // [RQ13]
        end

        // read mux; unmapped addresses read zero
        if (reg_cs && reg_rd) begin
            unique case (reg_addr)
                ltfc_pkg::OFS_FRAME_CTRL: rdata_nxt = fc_r;
                ltfc_pkg::OFS_TEST_CTRL:  rdata_nxt = {5'h00, freeze_r, crc_req_r,
                                                       fsw_req_r};
                ltfc_pkg::OFS_SLOT_SEL:   rdata_nxt = {2'b00, sel_r};
                ltfc_pkg::OFS_SAMPLE_HI:  rdata_nxt = sample_hi; // [RQ15]
                ltfc_pkg::OFS_SAMPLE_LO:  rdata_nxt = sample_lo; // [RQ16]
                default:                  rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fc_r        <= ltfc_pkg::FRAME_CTRL_RST;
            freeze_r    <= ltfc_pkg::TEST_CTRL_RST[ltfc_pkg::TC_FREEZE];
            crc_req_r   <= ltfc_pkg::TEST_CTRL_RST[ltfc_pkg::TC_CRC_INJ];
            fsw_req_r   <= ltfc_pkg::TEST_CTRL_RST[ltfc_pkg::TC_FSW_INJ];
            crc_act_r   <= 1'b0;
            fsw_act_r   <= 1'b0;
            sel_r       <= ltfc_pkg::SLOT_SEL_RST[ltfc_pkg::SEL_W-1:0];
            mem_r       <= 80'h0;
            wr_ptr_r    <= LEAD_PTR;
            rd_ptr_r    <= 7'h00;
            line_bit_r  <= 1'b0;
            ovf_r       <= 1'b0;
            unf_r       <= 1'b0;
            empty_r     <= 1'b0;
            frame_cnt_r <= 16'h0000;
            stuff_r     <= 1'b0;
            t1_pos_r    <= 8'h00;
            rdata_r     <= 8'h00;
            mk_s1_r     <= 1'b0;
            mk_s2_r     <= 1'b0;
            mk_s3_r     <= 1'b0;
        end else if (clk_en) begin
            fc_r        <= fc_nxt;
            freeze_r    <= freeze_nxt;
            crc_req_r   <= crc_req_nxt;
            fsw_req_r   <= fsw_req_nxt;
            crc_act_r   <= crc_act_nxt;
            fsw_act_r   <= fsw_act_nxt;
            sel_r       <= sel_nxt;
            mem_r       <= mem_nxt;
            wr_ptr_r    <= wr_ptr_nxt;
            rd_ptr_r    <= rd_ptr_nxt;
            line_bit_r  <= line_bit_nxt;
            ovf_r       <= ovf_nxt;
            unf_r       <= unf_nxt;
            empty_r     <= empty_nxt;
            frame_cnt_r <= frame_cnt_nxt;
            stuff_r     <= stuff_nxt;
            t1_pos_r    <= t1_pos_nxt;
            rdata_r     <= rdata_nxt;
            mk_s1_r     <= t1_frame_marker_in;
            mk_s2_r     <= mk_s1_r;
            mk_s3_r     <= mk_s2_r;
        end
    end

    // ------------------------------------------------------------
    // timeslot monitors: selected slot and the one after it
    // ------------------------------------------------------------
    ltfc_slot_sampler #(.SLOT_OFS(0)) u_sample_hi (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .bit_valid (t1_bit_valid),
        .bit_in    (t1_bit_in),
        .bit_pos   (t1_pos_r),
        .slot_sel  (sel_r),
        .sample    (sample_hi)
    );

    ltfc_slot_sampler #(.SLOT_OFS(1)) u_sample_lo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .bit_valid (t1_bit_valid),
        .bit_in    (t1_bit_in),
        .bit_pos   (t1_pos_r),
        .slot_sel  (sel_r),
        .sample    (sample_lo)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign frame_start        = clk_en && (frame_wrap || align_evt || frm_rst_evt);
    assign reg_rdata          = rdata_r;
    assign line_bit_out       = line_bit_r;
    assign actual_water_level = level_sat;
    assign stuff_four         = stuff_r;
    assign crc_corrupt        = crc_act_r;
    assign sync_word_corrupt  = fsw_act_r;
    assign overflow_flag      = ovf_r;
    assign underflow_flag     = unf_r;
    assign slip_irq           = ovf_r || unf_r;
    assign frame_empty_flag   = empty_r;
    assign frame_irq          = empty_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_level_scale: assert property (fc_r[ltfc_pkg::FC_LEVEL_FINE] && fill == 7'h00
        |-> actual_water_level == 8'h80) else $error("fine level scale wrong"); // [RQ1]
    a_fifo_reset: assert property (clk_en && fifo_rst_evt
        |=> rd_ptr_r == 7'h00 && wr_ptr_r == 7'd40) else $error("fifo reset failed"); // [RQ2]
    a_frame_reset: assert property (clk_en && frm_rst_evt
        |=> frame_cnt_r == 16'h0000) else $error("frame reset failed"); // [RQ3]
    a_align_off: assert property (clk_en && marker_rise && fc_r[ltfc_pkg::FC_ALIGN_DIS]
        && !frm_rst_evt && !line_bit_req |=> $stable(frame_cnt_r))
        else $error("marker moved frame while disabled"); // [RQ4]
    a_align_on: assert property (clk_en && marker_rise && !fc_r[ltfc_pkg::FC_ALIGN_DIS]
        |-> frame_start ##1 frame_cnt_r == 16'h0000) else $error("no forced alignment"); // [RQ5]
    a_slip_block: assert property (clk_en && fc_r[ltfc_pkg::FC_SLIP_DIS]
        |=> !slip_irq) else $error("slip flag while disabled"); // [RQ6]
    a_empty_block: assert property (clk_en && fc_r[ltfc_pkg::FC_EMPTY_DIS]
        |=> !frame_irq) else $error("frame flag while disabled"); // [RQ7]
    a_forced_stuff: assert property (frame_start && fc_r[ltfc_pkg::FC_FORCE_STUFF]
        |=> stuff_four != $past(stuff_four)) else $error("forced stuffing not alternating"); // [RQ8]
    a_auto_stuff: assert property (frame_start && !fc_r[ltfc_pkg::FC_FORCE_STUFF]
        |=> stuff_four == $past($signed(level_sat) < $signed(ref_water_level)))
        else $error("auto stuffing decision wrong"); // [RQ9]
    a_freeze_hold: assert property (clk_en && freeze_r && !fifo_rst_evt
        |=> $stable(wr_ptr_r) && $stable(mem_r)) else $error("write while frozen"); // [RQ10]
    a_crc_once: assert property (frame_start && crc_act_r && !wr_tc
        |=> !crc_req_r && !crc_corrupt) else $error("crc inject not cleared"); // [RQ11]
    a_fsw_once: assert property (frame_start && fsw_act_r && !wr_tc
        |=> !fsw_req_r && !sync_word_corrupt) else $error("sync inject not cleared"); // [RQ12]

    c_crc_inject: cover property (crc_act_r ##1 !crc_act_r);
    c_slip_alarm: cover property (slip_irq);
    c_forced_stuff: cover property (fc_r[ltfc_pkg::FC_FORCE_STUFF] && frame_start);
    c_marker_align: cover property (align_evt && clk_en);

endmodule : ltfc_top

// ===== tb_top.sv
// self-checking bench for the transmit framer control registers
`timescale 1ns/100ps
module tb_top;
    logic       ref_clk = 0, rst_n = 0, reg_cs = 0, reg_wr = 0, reg_rd = 0;
    logic       line_bit_req = 0, run = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, ref_water_level = 0, reg_rdata, lvl;
    logic       t1v, t1b, t1m, lbo, fs, stuff, crc, fsw, ovf, unf, sirq, empt, firq, s0;
    int         n_mismatch = 0;
    int         comparisons = 0;
    int         i, k, n_fs = 0;
    logic [79:0] cap;
    always #25 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (fs) n_fs <= n_fs + 1;
    ltfc_top #(.FRAME_BITS(64)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
        .reg_cs(reg_cs), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ref_water_level(ref_water_level),
        .t1_bit_valid(t1v), .t1_bit_in(t1b), .t1_frame_marker_in(t1m),
        .line_bit_req(line_bit_req), .line_bit_out(lbo), .actual_water_level(lvl),
        .frame_start(fs), .stuff_four(stuff), .crc_corrupt(crc), .sync_word_corrupt(fsw),
        .overflow_flag(ovf), .underflow_flag(unf), .slip_irq(sirq),
        .frame_empty_flag(empt), .frame_irq(firq));
    ltfc_t1_src i_t1 (.ref_clk(ref_clk), .run(run), .t1_bit_valid(t1v), .t1_bit_in(t1b),
        .t1_frame_marker_in(t1m));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        {reg_cs, reg_wr, reg_addr, reg_wdata} = {2'b11, a, d};
        @(negedge ref_clk);
        {reg_cs, reg_wr} = 2'b00;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk);
        {reg_cs, reg_rd, reg_addr} = {2'b11, a};
        @(negedge ref_clk);
        {reg_cs, reg_rd} = 2'b00;
        chk(reg_rdata, exp);
    endtask : rd
    task automatic lines(input int n);
        repeat (n) begin
            @(negedge ref_clk);
            line_bit_req = 1;
            @(negedge ref_clk);
            line_bit_req = 0;
        end
    endtask : lines
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge ref_clk);
        rst_n = 1;
        rd(8'ha3, 8'h08);
        rd(8'ha4, 8'h00);
        rd(8'ha5, 8'h00);
        rd(8'ha0, 8'h00);
        wr(8'ha5, 8'hff);
        rd(8'ha5, 8'h3f);
        wr(8'ha6, 8'h12);
        rd(8'ha6, 8'h00);
        chk(lvl, 8'h00);
        $display("test registers ended");
        lines(40);
        chk(lvl, 8'hb0);
        wr(8'ha3, 8'h48);
        chk(lvl, 8'h80);
        lines(1);
        chk({6'h0, unf, sirq}, 8'h03);
        wr(8'ha3, 8'h0c);
        @(negedge ref_clk);
        chk({6'h0, unf, sirq}, 8'h00);
        wr(8'ha3, 8'h28);
        wr(8'ha3, 8'h08);
        chk(lvl, 8'h00);
        $display("test level ended");
        wr(8'ha3, 8'h18);
        wr(8'ha3, 8'h08);
        chk({7'h0, empt}, 8'h01);
        wr(8'ha3, 8'h0a);
        @(negedge ref_clk);
        chk({6'h0, empt, firq}, 8'h00);
        wr(8'ha3, 8'h19);
        wr(8'ha3, 8'h09);
        s0 = stuff;
        wr(8'ha4, 8'h03);
        k = n_fs;
        lines(64);
        chk({5'h0, stuff, crc, fsw}, {5'h0, ~s0, 2'b11});
        lines(64);
        chk({5'h0, stuff, crc, fsw}, {5'h0, s0, 2'b00});
        chk(8'(n_fs - k), 8'h02);
        rd(8'ha4, 8'h00);
        ref_water_level = 8'h7f;
        wr(8'ha3, 8'h28);
        wr(8'ha3, 8'h18);
        wr(8'ha3, 8'h08);
        chk({7'h0, stuff}, 8'h01);
        ref_water_level = 8'h80;
        wr(8'ha3, 8'h18);
        wr(8'ha3, 8'h08);
        chk({7'h0, stuff}, 8'h00);
        $display("test frame ended");
        wr(8'ha4, 8'h04);
        rd(8'ha4, 8'h04);
        run = 1;
        repeat (500) @(negedge ref_clk);
        chk(lvl, 8'h00);
        wr(8'ha4, 8'h00);
        wr(8'ha3, 8'h0a);
        wr(8'ha3, 8'h08);
        repeat (450) @(negedge ref_clk);
        chk({7'h0, empt}, 8'h00);
        chk({6'h0, ovf, sirq}, 8'h03);
        wr(8'ha3, 8'h00);
        for (i = 0; i < 450 && empt !== 1'b1; i++) @(negedge ref_clk);
        chk({7'h0, empt}, 8'h01);
        if (empt !== 1'b1) tally_and_finish();
        wr(8'ha3, 8'h08);
        $display("test align ended");
        wr(8'ha5, 8'h05);
        repeat (800) @(negedge ref_clk);
        rd(8'ha6, 8'h5f);
        rd(8'ha7, 8'h5c);
        wr(8'ha5, 8'h17);
        repeat (800) @(negedge ref_clk);
        rd(8'ha6, 8'h4d);
        rd(8'ha7, 8'h5a);
        $display("test monitor ended");
        wr(8'ha4, 8'h04);
        for (i = 0; i < 160; i++) begin
            lines(1);
            if (i < 80) cap[i] = lbo;
            else chk({7'h0, lbo}, {7'h0, cap[i-80]});
        end
        $display("test replay ended");
        tally_and_finish();
    end
endmodule : tb_top
